/* common/arp_pkg.sv */
// Package of constants and types for the read request pipeline
package arp_pkg;
    localparam logic [2:0] START_CODE = 3'h7;
    localparam logic [3:0] CMD_READ = 4'h0;
    localparam logic [3:0] CMD_READ_HI = 4'h1;
    localparam int MAX_OUTSTANDING = 4;
    localparam logic [2:0] CNT_MAX = 3'h4;
    localparam logic [2:0] LEN_32B = 3'h3;
    localparam logic [8:0] SPLIT_LIMIT = 9'h040;
    localparam logic [8:0] CHUNK_BYTES = 9'h020;
    localparam int START_WAIT_MAX = 2;
    typedef struct packed {
        logic [28:0] addr;
        logic [2:0] len;
        logic [3:0] cmd;
    } arp_req_s;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_PIPE = 4'b0100,
        ST_LAST = 4'b1000
    } arp_state_e;
endpackage

/* hw/arp_outstanding.sv */
// Outstanding request counter
`timescale 1ns/100ps
module arp_outstanding (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_inc,
    input wire logic i_dec,
    output logic [2:0] o_count,
    output logic o_full
);
    logic [2:0] next_count;
    always_comb begin
        next_count = o_count;
        if (i_inc && !i_dec) begin
            next_count = o_count + 3'h1;
        end else if (i_dec && !i_inc && o_count != 3'h0) begin
            next_count = o_count - 3'h1;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_count <= 3'h0;
        end else begin
            o_count <= next_count;
        end
    end
    assign o_full = (o_count == arp_pkg::CNT_MAX);
    count_bound_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_count <= arp_pkg::CNT_MAX) else $error("count above four");
    count_step_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (i_inc && !i_dec) |=> o_count == $past(o_count) + 3'h1)
        else $error("count not stepped");
endmodule

/* hw/arp_request_pipe.sv */
// Pipelined read request issue engine for the graphics port
`timescale 1ns/100ps
module arp_request_pipe (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_rd_valid,
    input wire logic [31:0] i_rd_addr,
    input wire logic [8:0] i_rd_bytes,
    input wire logic i_stall_risk,
    output logic o_rd_ready,
    input wire logic i_reply_done,
    input wire logic i_slots_full,
    input wire logic i_pci_req,
    output logic o_pci_grant,
    input wire logic i_bus_grant_n,
    input wire logic [2:0] i_grant_status_code,
    input wire logic i_transaction_frame_n,
    output logic o_bus_request_n,
    output logic o_request_enqueue_strobe_n,
    output logic [31:0] o_shared_addr_data_bus,
    output logic o_ad_oe_n,
    output logic [3:0] o_command_byte_enable_n,
    output logic o_cbe_oe_n,
    output logic [2:0] o_outstanding
);
    arp_pkg::arp_state_e state, next_state;
    arp_pkg::arp_req_s cur, next_cur;
    logic [8:0] left, next_left;
    logic pci_own, next_pci_own;
    logic busy, next_busy;
    logic split, next_split;
    logic next_req_n, next_pipe_n, next_oe_n, next_pci_grant, next_rd_ready;
    logic [31:0] next_ad;
    logic [3:0] next_cbe;
    logic [2:0] count;
    logic full, enq, start, more, go;

    // Grant in START form only lets us place a request
    assign start = !i_bus_grant_n &&
        i_grant_status_code == arp_pkg::START_CODE;
    assign enq = !o_request_enqueue_strobe_n;
    // Another request may follow only if a slot and a chunk remain
    // Only a split read continues; a short read is always one request
    assign more = busy && split && left > arp_pkg::CHUNK_BYTES &&
        !i_slots_full && !(count == 3'h3 && !i_reply_done);
    // Slot and count limits hold a pending read back in idle
    assign go = busy && !full && !i_slots_full;

    arp_outstanding u_cnt (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_inc(enq),
        .i_dec(i_reply_done),
        .o_count(count),
        .o_full(full)
    );

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_left = left;
        next_busy = busy;
        next_pci_own = pci_own;
        next_split = split;
        next_req_n = o_bus_request_n;
        next_pipe_n = 1'b1;
        next_oe_n = 1'b1;
        next_ad = 32'h0;
        next_cbe = 4'hf;
        next_pci_grant = 1'b0;
        case (state)
            arp_pkg::ST_IDLE: begin
                if (!busy && i_rd_valid) begin
                    next_busy = 1'b1;
                    next_left = i_rd_bytes;
                    next_cur.addr = i_rd_addr[31:3];
                    next_split = i_rd_bytes > arp_pkg::SPLIT_LIMIT;
                    // Long reads go out as fixed chunks
                    next_cur.len = (i_rd_bytes > arp_pkg::SPLIT_LIMIT) ?
                        arp_pkg::LEN_32B :
                        3'((i_rd_bytes - 9'h1) >> 3);
                    next_cur.cmd = i_stall_risk ? arp_pkg::CMD_READ_HI :
                        arp_pkg::CMD_READ;
                end
                if (go || i_pci_req) begin
                    next_pci_own = !go;
                    next_req_n = 1'b0;
                    next_state = arp_pkg::ST_WAIT;
                end
            end
            arp_pkg::ST_WAIT: begin
                if (start) begin
                    if (pci_own) begin
                        // Ordinary transaction runs between pipe phases
                        next_pci_grant = 1'b1;
                        next_req_n = 1'b1;
                        next_pci_own = 1'b0;
                        next_state = arp_pkg::ST_IDLE;
                    end else begin
                        next_pipe_n = 1'b0;
                        next_oe_n = 1'b0;
                        next_ad = {cur.addr, cur.len};
                        next_cbe = ~cur.cmd;
                        next_req_n = !more;
                        next_state = more ? arp_pkg::ST_PIPE :
                            arp_pkg::ST_LAST;
                    end
                end
            end
            arp_pkg::ST_PIPE: begin
                next_cur.addr = cur.addr + 29'h4;
                next_left = left - arp_pkg::CHUNK_BYTES;
                next_cur.len = arp_pkg::LEN_32B;
                next_pipe_n = 1'b0;
                next_oe_n = 1'b0;
                next_ad = {next_cur.addr, next_cur.len};
                next_cbe = ~cur.cmd;
                next_req_n = !(next_left > arp_pkg::CHUNK_BYTES &&
                    !i_slots_full && count < 3'h2);
                next_state = next_req_n ? arp_pkg::ST_LAST :
                    arp_pkg::ST_PIPE;
            end
            arp_pkg::ST_LAST: begin
                // Strobe drops once request was seen high
                next_req_n = 1'b1;
                if (split && left > arp_pkg::CHUNK_BYTES) begin
                    next_left = left - arp_pkg::CHUNK_BYTES;
                    next_cur.addr = cur.addr + 29'h4;
                    next_cur.len = arp_pkg::LEN_32B;
                end else begin
                    next_busy = 1'b0;
                    next_split = 1'b0;
                end
                next_state = arp_pkg::ST_IDLE;
            end
            default: begin
                next_state = arp_pkg::ST_IDLE;
            end
        endcase
        next_rd_ready = (next_state == arp_pkg::ST_IDLE) && !next_busy;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= arp_pkg::ST_IDLE;
            cur <= '0;
            left <= 9'h0;
            busy <= 1'b0;
            pci_own <= 1'b0;
            split <= 1'b0;
            o_bus_request_n <= 1'b1;
            o_request_enqueue_strobe_n <= 1'b1;
            o_ad_oe_n <= 1'b1;
            o_cbe_oe_n <= 1'b1;
            o_shared_addr_data_bus <= 32'h0;
            o_command_byte_enable_n <= 4'hf;
            o_pci_grant <= 1'b0;
            o_outstanding <= 3'h0;
            o_rd_ready <= 1'b1;
        end else begin
            state <= next_state;
            cur <= next_cur;
            left <= next_left;
            busy <= next_busy;
            pci_own <= next_pci_own;
            split <= next_split;
            o_bus_request_n <= next_req_n;
            o_request_enqueue_strobe_n <= next_pipe_n;
            o_ad_oe_n <= next_oe_n;
            o_cbe_oe_n <= next_oe_n;
            o_shared_addr_data_bus <= next_ad;
            o_command_byte_enable_n <= next_cbe;
            o_pci_grant <= next_pci_grant;
            o_outstanding <= count;
            o_rd_ready <= next_rd_ready;
        end
    end

    strobe_start_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (start && state == arp_pkg::ST_WAIT && !pci_own)
        |=> !o_request_enqueue_strobe_n) else $error("late strobe");
    strobe_after_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        (!o_request_enqueue_strobe_n && o_bus_request_n)
        |=> o_request_enqueue_strobe_n) else $error("strobe kept");
    cmd_legal_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !o_request_enqueue_strobe_n |-> (o_command_byte_enable_n == 4'hf ||
        o_command_byte_enable_n == 4'he)) else $error("bad cmd");
    no_enq_full_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !o_request_enqueue_strobe_n |-> count < arp_pkg::CNT_MAX)
        else $error("enqueue while full");
    len_chunk_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !o_request_enqueue_strobe_n && split |->
        o_shared_addr_data_bus[2:0] == arp_pkg::LEN_32B)
        else $error("chunk not 32 bytes");
    drive_oe_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        !o_request_enqueue_strobe_n |-> !o_ad_oe_n && !o_cbe_oe_n)
        else $error("bus not driven");
    last_mark_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        $rose(o_bus_request_n) && state == arp_pkg::ST_LAST
        |-> !o_request_enqueue_strobe_n) else $error("last unmarked");
    pci_gnt_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_nrst)
        o_pci_grant |-> o_request_enqueue_strobe_n)
        else $error("pci and pipe overlap");
endmodule

/* tb/arp_bridge_model.sv */
// Bridge model: bus arbiter and memory reply source
`timescale 1ns/100ps
module arp_bridge_model (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_bus_request_n,
    input wire logic i_request_enqueue_strobe_n,
    input wire logic i_hold,
    input wire logic [1:0] i_lag,
    output logic o_bus_grant_n,
    output logic [2:0] o_grant_status_code,
    output logic o_reply_done,
    output int o_pending
);
    int lag_cnt;
    logic used;
    always @(negedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bus_grant_n <= 1'b1;
            o_grant_status_code <= 3'h0;
            o_reply_done <= 1'b0;
            o_pending <= 0;
            lag_cnt <= 0;
            used <= 1'b0;
        end else begin
            o_pending <= o_pending + int'(!i_request_enqueue_strobe_n)
                - int'(o_reply_done);
            // Every other cycle while requests are pending; i_hold holds replies off to model a stalled memory
            o_reply_done <= !i_hold && !o_reply_done && o_pending > 0;
            if (!i_request_enqueue_strobe_n || i_bus_request_n) begin
                o_bus_grant_n <= 1'b1;
                o_grant_status_code <= 3'h0;
                lag_cnt <= 0;
            end else if (!used && lag_cnt >= int'(i_lag)) begin
                o_bus_grant_n <= 1'b0;
                o_grant_status_code <= 3'h7;
            end else begin
                lag_cnt <= lag_cnt + 1;
            end
            used <= !i_bus_request_n
                && (used || !i_request_enqueue_strobe_n);
        end
    end
endmodule

/* tb/test_agp_read_request_pipeline.sv */
// Testbench for the pipelined read request engine
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("ERROR %0t: got %h want %h", $time, g, e); \
    end end
module test_agp_read_request_pipeline;
    logic clk, nrst, valid, hi, hold, slots, pci, reply, grant_n, ready;
    logic pci_grant, req_n, stb_n, ad_oe_n, cbe_oe_n, pstb, preq, agp;
    logic [31:0] addr, bus;
    logic [8:0] bytes;
    logic [2:0] code, outst;
    logic [3:0] cbe;
    logic [1:0] lag;
    int pend, gcnt;
    int bad_count = 0;
    int total_checks = 0;
    logic [36:0] seen[$];
    arp_request_pipe dut_u (.i_sys_clk(clk), .i_nrst(nrst),
        .i_rd_valid(valid), .i_rd_addr(addr), .i_rd_bytes(bytes),
        .i_stall_risk(hi), .o_rd_ready(ready), .i_reply_done(reply),
        .i_slots_full(slots), .i_pci_req(pci), .o_pci_grant(pci_grant),
        .i_bus_grant_n(grant_n), .i_grant_status_code(code),
        .i_transaction_frame_n(1'b1), .o_bus_request_n(req_n),
        .o_request_enqueue_strobe_n(stb_n), .o_shared_addr_data_bus(bus),
        .o_ad_oe_n(ad_oe_n), .o_command_byte_enable_n(cbe),
        .o_cbe_oe_n(cbe_oe_n), .o_outstanding(outst));
    arp_bridge_model bridge_u (.i_sys_clk(clk), .i_nrst(nrst),
        .i_bus_request_n(req_n), .i_request_enqueue_strobe_n(stb_n),
        .i_hold(hold), .i_lag(lag), .o_bus_grant_n(grant_n),
        .o_grant_status_code(code), .o_reply_done(reply),
        .o_pending(pend));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (nrst) begin
            if (!stb_n) begin
                `CHK({ad_oe_n, cbe_oe_n}, 2'b00)
                seen.push_back({bus, cbe, req_n});
            end
            if (!pstb && preq) `CHK(stb_n, 1'b1)
            `CHK(pend <= 4 && outst <= 3'h4, 1'b1)
            gcnt = (!grant_n && stb_n && agp) ? gcnt + 1 : 0;
            `CHK(gcnt <= 2, 1'b1)
        end else begin
            gcnt = 0;
        end
        pstb = nrst ? stb_n : 1'b1;
        preq = req_n;
    end
    task automatic stop_test;
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic do_read(input logic [31:0] a, input logic [8:0] b,
        input logic h, input int n, input logic [2:0] len,
        input logic [3:0] marks);
        int k;
        logic [36:0] exp;
        seen.delete();
        k = 0;
        @(negedge clk);
        agp = 1'b1;
        valid = 1'b1;
        addr = a;
        bytes = b;
        hi = h;
        while (ready !== 1'b1 && k < 300) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        valid = 1'b0;
        while ((seen.size() < n || stb_n !== 1'b1) && k < 600) begin
            @(negedge clk);
            k++;
        end
        `CHK(seen.size(), n)
        for (int i = 0; i < n; i++) begin
            exp = {a[31:3] + 29'(4 * i), len, h ? 4'he : 4'hf, marks[i]};
            `CHK(seen[i], exp)
        end
    endtask
    task automatic do_pci;
        int k;
        k = 0;
        @(negedge clk);
        agp = 1'b0;
        pci = 1'b1;
        while (pci_grant !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        `CHK(pci_grant, 1'b1)
        pci = 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        stop_test();
    end
    initial begin
        {nrst, valid, hi, hold, slots, pci, agp, lag} = 9'h000;
        addr = 32'h0;
        bytes = 9'h0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        do_read(32'h0000_1000, 9'h020, 1'b0, 1, 3'h3, 4'h1);
        lag = 2'h2;
        do_read(32'h0000_2040, 9'h040, 1'b1, 1, 3'h7, 4'h1);
        lag = 2'h0;
        repeat (10) @(negedge clk);
        hold = 1'b1;
        do_read(32'h0001_0000, 9'h080, 1'b0, 4, 3'h3, 4'h8);
        // The count output trails the counter by one clock
        @(negedge clk);
        `CHK(outst, 3'h4)
        // Memory stays silent so the fifth request must wait for a reply;
        // with the counter at two the second chunk closes the bus operation
        // and the third one needs a fresh grant
        fork
            begin
                repeat (40) @(negedge clk);
                hold = 1'b0;
            end
        join_none
        do_read(32'h0002_0020, 9'h060, 1'b1, 3, 3'h3, 4'h6);
        slots = 1'b1;
        fork
            begin
                repeat (20) @(negedge clk);
                `CHK(seen.size(), 0)
                slots = 1'b0;
            end
        join_none
        do_read(32'h0003_0000, 9'h020, 1'b0, 1, 3'h3, 4'h1);
        do_pci();
        repeat (10) @(negedge clk);
        stop_test();
    end
endmodule
